// ==== design/mimi_regs.vh ====
// Register map, field positions and reset values of the modem interrupt mask and index block
// Functional notes
// RULE1: Transmit-done interrupt is never raised while mask bit 1 is 0; resets to 0.
// RULE2: Modem-ready interrupt is gated by mask bit 0; bit resets to 0.
// RULE3: On receive-done, index bit 4 holds the received packet's rate flag.
// RULE4: Simultaneous interrupts are buffered and presented one by one in fixed order.
// RULE5: Each read of the index register retires the interrupt it just reported.
// RULE6: Writing 1 to index bit 3 clears every buffered interrupt; bit resets to 1.
// RULE7: Index code 0 modem-ready, 1 transmit-done, 2 receive-begin, 3 receive-done; resets 00.
// RULE8: Receive-done interrupt is never generated while its mask bit is 0.
// RULE9: Interrupt request is high while the buffer holds an interrupt, low once empty. Code also holds it high while any status bit with its enable bit set is 1.
`ifndef MIMI_REGS_VH
`define MIMI_REGS_VH

`define MIMI_ADDR_W         16
`define MIMI_ADDR_INDEX     16'h2278
`define MIMI_ADDR_MASK      16'h227c
`define MIMI_ADDR_STATUS    16'h2280
`define MIMI_ADDR_ENABLE    16'h2284
`define MIMI_ADDR_CLEAR     16'h2288

`define MIMI_NUM_IRQ        4
`define MIMI_IRQ_MRDY       0
`define MIMI_IRQ_TXDONE     1
`define MIMI_IRQ_RXBEGIN    2
`define MIMI_IRQ_RXDONE     3

`define MIMI_IDX_CLRALL     3
`define MIMI_IDX_RATE       4

`define MIMI_MASK_RST       4'h0
`define MIMI_MASK_RSVD      4'hf
`define MIMI_CLRALL_RST     1'b1
`define MIMI_RATE_RST       1'b1
`define MIMI_IDX_RSVD_HI    3'h7
`define MIMI_IDX_RSVD_B2    1'b1

`endif

// ==== design/mimi_apb_slave.v ====
// APB slave front end: phase decode, strobes and registered read data
`timescale 1ns/10ps
`default_nettype none
module mimi_apb_slave (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire        i_hit,
    input  wire [31:0] i_rdata,
    output wire        o_setup,
    output wire        o_wr_stb,
    output wire        o_rd_stb,
    output wire        o_pready,
    output wire        o_pslverr,
    output reg  [31:0] o_prdata
);
    wire access;

    assign o_setup   = i_psel & ~i_penable;
    assign access    = i_psel & i_penable;
    // Zero wait states: read data is captured during setup, so the access phase always completes
    assign o_pready  = access;
    assign o_pslverr = access & ~i_hit;
    assign o_wr_stb  = access & i_pwrite & i_hit;
    assign o_rd_stb  = access & ~i_pwrite & i_hit;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h0;
        end else if (o_setup) begin
            o_prdata <= (i_pwrite | ~i_hit) ? 32'h0 : i_rdata;
        end
    end
endmodule
`default_nettype wire

// ==== design/mimi_irq_queue.v ====
// Pending interrupt buffer with fixed-order head selection
`timescale 1ns/10ps
`default_nettype none
module mimi_irq_queue #(
    parameter N  = 4,
    parameter IW = 2
) (
    input  wire          i_clk,
    input  wire          i_rst,
    input  wire [N-1:0]  i_set,
    input  wire          i_pop,
    input  wire [IW-1:0] i_pop_idx,
    input  wire          i_clr_all,
    output reg  [N-1:0]  o_pend,
    output reg  [IW-1:0] o_head,
    output wire          o_nonempty
);
    genvar g;
    integer k;

    generate
        for (g = 0; g < N; g = g + 1) begin : g_slot
            wire pop_hit;
            // Index widened to the genvar's width so the compare neither drops nor pads bits
            assign pop_hit = i_pop && ({{(32-IW){1'b0}}, i_pop_idx} == g);
            // A new event in the same cycle as its clear keeps the slot pending
            always @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    o_pend[g] <= 1'b0;
                end else if (i_set[g]) begin
                    o_pend[g] <= 1'b1; // [RULE4]
                end else if (i_clr_all) begin
                    o_pend[g] <= 1'b0; // [RULE6]
                end else if (pop_hit) begin
                    o_pend[g] <= 1'b0; // [RULE5]
                end
            end
        end
    endgenerate

    // Lowest code is served first; empty buffer reports 00
    always @* begin
        o_head = {IW{1'b0}};
        for (k = N - 1; k >= 0; k = k - 1) begin
            if (o_pend[k]) begin
                o_head = k[IW-1:0]; // [RULE4] [RULE7]
            end
        end
    end

    assign o_nonempty = |o_pend;
endmodule
`default_nettype wire

// ==== design/mimi_top.v ====
// Modem interrupt masking, queuing and index block with APB register access
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "mimi_regs.vh"
module mimi_top (
    input  wire                    I_MCLK,
    input  wire                    I_RST,
    input  wire                    I_PSEL,
    input  wire                    I_PENABLE,
    input  wire                    I_PWRITE,
    input  wire [`MIMI_ADDR_W-1:0] I_PADDR,
    input  wire [31:0]             I_PWDATA,
    output wire                    O_PREADY,
    output wire                    O_PSLVERR,
    output wire [31:0]             O_PRDATA,
    input  wire                    I_MODEM_READY_EVT,
    input  wire                    I_TX_DONE_EVT,
    input  wire                    I_RX_BEGIN_EVT,
    input  wire                    I_RX_DONE_EVT,
    input  wire                    I_RX_FAST_RATE,
    output wire                    O_IRQ
);
    localparam N = `MIMI_NUM_IRQ;

    reg  [N-1:0] mask;
    reg  [N-1:0] status;
    reg  [N-1:0] enable;
    reg          clear_all_pending;
    reg          rx_fast_rate_flag;
    reg          pop_valid;
    reg  [1:0]   pop_idx;
    reg          hit;
    reg  [31:0]  rdata;

    wire [N-1:0] raw_evt;
    wire [N-1:0] gated_evt;
    wire [N-1:0] pend;
    wire [1:0]   pending_irq_index;
    wire         nonempty;
    wire         setup;
    wire         wr_stb;
    wire         rd_stb;
    wire         wr_index;
    wire         clr_all_now;
    wire         sel_index;

    assign raw_evt = {I_RX_DONE_EVT, I_RX_BEGIN_EVT, I_TX_DONE_EVT, I_MODEM_READY_EVT};
    // Mask bit 0 blocks its interrupt entirely; nothing reaches buffer or status
    assign gated_evt = raw_evt & mask; // [RULE1] [RULE2] [RULE8]

    assign sel_index   = (I_PADDR == `MIMI_ADDR_INDEX);
    assign wr_index    = wr_stb & sel_index;
    assign clr_all_now = wr_index & I_PWDATA[`MIMI_IDX_CLRALL]; // [RULE6]

    always @* begin
        hit   = 1'b1;
        rdata = 32'h0;
        if (I_PADDR == `MIMI_ADDR_INDEX) begin
            rdata[7:0] = {`MIMI_IDX_RSVD_HI, rx_fast_rate_flag, clear_all_pending,
                          `MIMI_IDX_RSVD_B2, pending_irq_index}; // [RULE3] [RULE7]
        end else if (I_PADDR == `MIMI_ADDR_MASK) begin
            rdata[7:0] = {`MIMI_MASK_RSVD, mask};
        end else if (I_PADDR == `MIMI_ADDR_STATUS) begin
            rdata[N-1:0] = status;
        end else if (I_PADDR == `MIMI_ADDR_ENABLE) begin
            rdata[N-1:0] = enable;
        end else if (I_PADDR == `MIMI_ADDR_CLEAR) begin
            rdata = 32'h0;
        end else begin
            hit = 1'b0;
        end
    end

    mimi_apb_slave u_apb (
        .i_clk     (I_MCLK),
        .i_rst     (I_RST),
        .i_psel    (I_PSEL),
        .i_penable (I_PENABLE),
        .i_pwrite  (I_PWRITE),
        .i_hit     (hit),
        .i_rdata   (rdata),
        .o_setup   (setup),
        .o_wr_stb  (wr_stb),
        .o_rd_stb  (rd_stb),
        .o_pready  (O_PREADY),
        .o_pslverr (O_PSLVERR),
        .o_prdata  (O_PRDATA)
    );

    // The index is latched with the read data so the slot retired is the one software saw
    always @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            pop_valid <= 1'b0;
            pop_idx   <= 2'h0;
        end else if (setup) begin
            pop_valid <= sel_index & ~I_PWRITE & nonempty;
            pop_idx   <= pending_irq_index;
        end
    end

    mimi_irq_queue #(
        .N  (N),
        .IW (2)
    ) u_queue (
        .i_clk      (I_MCLK),
        .i_rst      (I_RST),
        .i_set      (gated_evt),
        .i_pop      (rd_stb & sel_index & pop_valid), // [RULE5]
        .i_pop_idx  (pop_idx),
        .i_clr_all  (clr_all_now),
        .o_pend     (pend),
        .o_head     (pending_irq_index),
        .o_nonempty (nonempty)
    );

    always @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            mask              <= `MIMI_MASK_RST; // [RULE1] [RULE2]
            enable            <= {N{1'b0}};
            clear_all_pending <= `MIMI_CLRALL_RST; // [RULE6]
        end else if (wr_stb) begin
            if (I_PADDR == `MIMI_ADDR_MASK) begin
                mask <= I_PWDATA[N-1:0];
            end else if (I_PADDR == `MIMI_ADDR_ENABLE) begin
                enable <= I_PWDATA[N-1:0];
            end else if (I_PADDR == `MIMI_ADDR_INDEX) begin
                clear_all_pending <= I_PWDATA[`MIMI_IDX_CLRALL];
            end
        end
    end

    // Rate flag follows the packet whose receive-done was accepted; software may also write it
    always @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            rx_fast_rate_flag <= `MIMI_RATE_RST;
        end else if (gated_evt[`MIMI_IRQ_RXDONE]) begin
            rx_fast_rate_flag <= I_RX_FAST_RATE; // [RULE3]
        end else if (wr_index) begin
            rx_fast_rate_flag <= I_PWDATA[`MIMI_IDX_RATE];
        end
    end

    // Sticky status: a set in the clear cycle wins
    always @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            status <= {N{1'b0}};
        end else if (wr_stb && I_PADDR == `MIMI_ADDR_CLEAR) begin
            status <= (status & ~I_PWDATA[N-1:0]) | gated_evt;
        end else begin
            status <= status | gated_evt;
        end
    end

    assign O_IRQ = nonempty | (|(status & enable)); // [RULE9]

    wire unused_ok;
    assign unused_ok = &{1'b0, pend};
endmodule
`default_nettype wire

// ==== testbench/mimi_top_properties.sv ====
// Port-level checker for the modem interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "mimi_regs.vh"
module mimi_top_properties (
    input wire logic        I_MCLK,
    input wire logic        I_RST,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [15:0] I_PADDR,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    input wire logic [31:0] O_PRDATA,
    input wire logic        I_MODEM_READY_EVT,
    input wire logic        I_TX_DONE_EVT,
    input wire logic        I_RX_BEGIN_EVT,
    input wire logic        I_RX_DONE_EVT,
    input wire logic        O_IRQ
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    wire logic acc = I_PSEL && I_PENABLE;
    wire logic evt = I_MODEM_READY_EVT || I_TX_DONE_EVT || I_RX_BEGIN_EVT || I_RX_DONE_EVT;
    wire logic map = I_PADDR >= 16'h2278 && I_PADDR <= 16'h2288 && I_PADDR[1:0] == 2'h0;
    sequence rd_at(logic [15:0] a);
        acc && !I_PWRITE && I_PADDR == a;
    endsequence
    ready_follows_a: assert property (O_PREADY == acc)
        else $error("pready differs from access phase");
    err_unmapped_a: assert property (acc |-> O_PSLVERR == !map)
        else $error("pslverr wrong for address");
    rdata_zero_a: assert property (acc && (I_PWRITE || !map || I_PADDR == `MIMI_ADDR_CLEAR) |-> O_PRDATA == 32'h0)
        else $error("read data not zero");
    index_shape_a: assert property (rd_at(`MIMI_ADDR_INDEX) |-> O_PRDATA[31:5] == 27'h7 && O_PRDATA[2])
        else $error("index fixed bits wrong");
    mask_shape_a: assert property (rd_at(`MIMI_ADDR_MASK) |-> O_PRDATA[31:4] == 28'hf)
        else $error("mask upper bits wrong");
    status_shape_a: assert property (rd_at(`MIMI_ADDR_STATUS) |-> O_PRDATA[31:4] == 28'h0)
        else $error("status upper bits wrong");
    head_irq_a: assert property (rd_at(`MIMI_ADDR_INDEX) ##0 O_PRDATA[1:0] != 2'h0 |-> O_IRQ)
        else $error("pending code without request");
    irq_rise_a: assert property ($rose(O_IRQ) |-> $past(evt || (acc && I_PWRITE)))
        else $error("request rose without cause");
    irq_fall_a: assert property ($fell(O_IRQ) |-> $past(acc))
        else $error("request fell without access");
endmodule
bind mimi_top mimi_top_properties mimi_top_properties_inst (
    .I_MCLK(I_MCLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_PRDATA(O_PRDATA), .I_MODEM_READY_EVT(I_MODEM_READY_EVT), .I_TX_DONE_EVT(I_TX_DONE_EVT),
    .I_RX_BEGIN_EVT(I_RX_BEGIN_EVT), .I_RX_DONE_EVT(I_RX_DONE_EVT), .O_IRQ(O_IRQ));
`default_nettype wire

// ==== testbench/mimi_top_tb.sv ====
// Self-checking bench for the modem interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "mimi_regs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got %h", $time, g); end end
module mimi_top_tb;
    localparam logic [15:0] AI = `MIMI_ADDR_INDEX;
    localparam logic [15:0] AM = `MIMI_ADDR_MASK;
    localparam logic [15:0] AS = `MIMI_ADDR_STATUS;
    localparam logic [15:0] AE = `MIMI_ADDR_ENABLE;
    localparam logic [15:0] AC = `MIMI_ADDR_CLEAR;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [15:0] padr = 16'h0;
    logic [31:0] pwd = 32'h0;
    logic [3:0]  evt = 4'h0;
    logic        fast = 1'b0;
    wire logic        pready;
    wire logic        pslverr;
    wire logic [31:0] prdata;
    wire logic        irq;
    logic [31:0] rd;
    logic        er;
    int          failures = 0;
    int          checks = 0;
    always #5 clk = ~clk;
    mimi_top mimi_top_inst (.I_MCLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_PRDATA(prdata), .I_MODEM_READY_EVT(evt[0]), .I_TX_DONE_EVT(evt[1]),
        .I_RX_BEGIN_EVT(evt[2]), .I_RX_DONE_EVT(evt[3]), .I_RX_FAST_RATE(fast), .O_IRQ(irq));
    task automatic print_verdict();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Bounded wait: a stuck pready ends the run instead of hanging it
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 16) begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic pulse(input logic [3:0] e, input logic f);
        @(posedge clk);
        evt <= e;
        fast <= f;
        @(posedge clk);
        evt <= 4'h0;
        #1;
    endtask
    task automatic t_reset();
        apb(1'b0, AI, 32'h0);
        `CHK(rd, 32'hfc)
        apb(1'b0, AM, 32'h0);
        `CHK(rd, 32'hf0)
        apb(1'b0, 16'h2290, 32'h0);
        `CHK({er, rd}, 33'h100000000)
    endtask
    task automatic t_masked();
        pulse(4'hf, 1'b1);
        `CHK(irq, 1'b0)
        apb(1'b0, AS, 32'h0);
        `CHK(rd, 32'h0)
    endtask
    // All four at once must come out lowest code first, one per read
    task automatic t_order();
        apb(1'b1, AM, 32'hf);
        pulse(4'hf, 1'b0);
        `CHK(irq, 1'b1)
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, AI, 32'h0);
            `CHK(rd, 32'hec + 32'(i))
        end
        #1;
        `CHK(irq, 1'b0)
    endtask
    task automatic t_clear();
        apb(1'b1, AM, 32'h9);
        apb(1'b1, AC, 32'hf);
        apb(1'b1, AE, 32'h8);
        pulse(4'hf, 1'b1);
        apb(1'b0, AS, 32'h0);
        `CHK(rd, 32'h9)
        apb(1'b0, AI, 32'h0);
        `CHK(rd, 32'hfc)
        apb(1'b1, AI, 32'h08);
        apb(1'b0, AI, 32'h0);
        `CHK(rd, 32'hec)
        `CHK(irq, 1'b1)
        apb(1'b1, AC, 32'h8);
        #1;
        `CHK(irq, 1'b0)
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_masked();
        t_order();
        t_clear();
        print_verdict();
    end
endmodule
`default_nettype wire
